// >>> hdl/base_tick_gen.sv
// fractional tick generator: one-cycle enable pulses at the trimmed base rate
// assumes a 20 MHz clock; trim may change at any time
`timescale 1ns/1ps
module base_tick_gen
    import lowside_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic [1:0] trim,
    // tick out
    output logic tick
);
    logic [8:0] acc_r;
    logic [8:0] acc_nxt;

    // phase accumulator, rollover marks a tick; jitter is one clock at most
    assign acc_nxt = acc_r + trim_increment(trim);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r <= 9'h000;
            tick <= 1'b0;
        end else if (acc_nxt >= ACC_MOD) begin
            acc_r <= acc_nxt - ACC_MOD;
            tick <= 1'b1;
        end else begin
            acc_r <= acc_nxt;
            tick <= 1'b0;
        end
    end
endmodule // base_tick_gen

// >>> hdl/lowside_ctrl_pkg.sv
// constants, field codes and small decoders for the low-side channel controller
// assumes one 20 MHz system clock; the internal base rate is made from it by ticks
package lowside_ctrl_pkg;

    localparam int NUM_CH = 8;
    localparam int CNT_W = 19;

    // clock rates
    localparam int CLK_MHZ = 20;
    localparam int BASE_MHZ = 8;

    // base tick accumulator: inc/mod of CLK_MHZ gives the base rate
    localparam logic [8:0] ACC_MOD = 9'h0c8;
    localparam logic [8:0] INC_NOM = 9'(ACC_MOD * BASE_MHZ / CLK_MHZ);
    localparam logic [8:0] INC_FAST = 9'h05c; // divider shortened by 13 percent
    localparam logic [8:0] INC_SLOW = 9'h044; // divider lengthened by 18 percent

    // trim codes
    localparam logic [1:0] TRIM_NONE = 2'h0;
    localparam logic [1:0] TRIM_MINUS = 2'h1;
    localparam logic [1:0] TRIM_PLUS = 2'h2;

    // channel command sources
    localparam logic [1:0] SRC_SPI = 2'h0;
    localparam logic [1:0] SRC_GEN = 2'h1;
    localparam logic [1:0] SRC_LED = 2'h2;
    localparam logic [1:0] SRC_PIN = 2'h3;

    // pwm period: 255 steps of a prescaled base tick
    localparam logic [7:0] STEP_LAST = 8'hfe;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [7:0] DUTY_ZERO = 8'h00;

    // times in their own units, counts in base ticks
    localparam int WINDOW_MS = 40;
    localparam int RESTART_US = 1000;
    localparam int INIT_US = 1000;
    localparam int WINDOW_TICKS_DEF = WINDOW_MS * 1000 * BASE_MHZ;
    localparam int RESTART_TICKS_DEF = RESTART_US * BASE_MHZ;
    localparam int INIT_TICKS_DEF = INIT_US * BASE_MHZ;
    localparam logic [CNT_W-1:0] CNT_ONE = 19'h00001;

    // accumulator step for a trim code
    function automatic logic [8:0] trim_increment(input logic [1:0] trim);
        case (trim)
            TRIM_MINUS: trim_increment = INC_FAST;
            TRIM_PLUS: trim_increment = INC_SLOW;
            default: trim_increment = INC_NOM;
        endcase
    endfunction

    // last prescaler count for a frequency select: 256, 128, 64, 32 ticks
    function automatic logic [7:0] div_limit(input logic [1:0] sel);
        div_limit = 8'(9'h100 >> sel) - 8'h01;
    endfunction

endpackage

// >>> hdl/lowside_inrush_and_pwm_control.sv
// per-channel on/off control with overload latching, bulb inrush restart,
// threshold selection, and the two internal pwm generators
// assumes command strobes are one-cycle pulses and all inputs are clk-synchronous;
// overcurrent_event is the comparator against the threshold this block selects
`timescale 1ns/1ps
module lowside_inrush_and_pwm_control
    import lowside_ctrl_pkg::*;
#(
    parameter logic [CNT_W-1:0] WINDOW_TICKS = CNT_W'(WINDOW_TICKS_DEF),
    parameter logic [CNT_W-1:0] RESTART_TICKS = CNT_W'(RESTART_TICKS_DEF),
    parameter logic [CNT_W-1:0] INIT_TICKS = CNT_W'(INIT_TICKS_DEF)
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // direct channel commands
    input wire logic [7:0] spi_on_cmd,
    // channel source mapping, two bits per channel
    input wire logic [15:0] chan_src_sel,
    input wire logic [7:0] parallel_map_zero,
    input wire logic [7:0] parallel_map_one,
    // parallel pins
    input wire logic parallel_input_zero,
    input wire logic parallel_input_one,
    // inrush mode write
    input wire logic inrush_wr,
    input wire logic [7:0] inrush_wdata,
    // overload flag clear
    input wire logic flag_clr_wr,
    input wire logic [7:0] flag_clr_mask,
    // general pwm unit
    input wire logic general_duty_wr,
    input wire logic [7:0] general_duty_value,
    input wire logic [1:0] general_freq_select,
    // led pwm unit
    input wire logic led_duty_wr,
    input wire logic [7:0] led_duty_value,
    input wire logic [1:0] led_freq_select,
    // shared trim
    input wire logic [1:0] freq_trim_select,
    // power stage sense
    input wire logic [7:0] overcurrent_event,
    input wire logic [7:0] overtemperature_event,
    // channel outputs
    output logic [7:0] channel_drive,
    output logic [7:0] high_threshold_sel,
    // status
    output logic [7:0] overload_latch_flags,
    output logic [7:0] inrush_enable_bit,
    output logic [7:0] inrush_window_run,
    output logic general_pwm_active,
    output logic led_pwm_active
);

    // command source decode; pin zero outranks pin one on a shared channel
    function automatic logic src_cmd(
        input logic [1:0] sel,
        input logic spi_bit,
        input logic gen_out,
        input logic led_out,
        input logic map0,
        input logic map1,
        input logic pin0,
        input logic pin1
    );
        case (sel)
            SRC_SPI: src_cmd = spi_bit;
            SRC_GEN: src_cmd = gen_out;
            SRC_LED: src_cmd = led_out;
            SRC_PIN: src_cmd = map0 ? pin0 : (map1 & pin1);
            default: src_cmd = 1'b0;
        endcase
    endfunction

    logic base_tick;
    logic pwm_tick;

    pwm_if gen_bus();
    pwm_if led_bus();

    // untrimmed base tick times the protection windows
    base_tick_gen u_base_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .trim(TRIM_NONE),
        .tick(base_tick)
    );

    // trimmed tick is shared by both pwm prescalers
    base_tick_gen u_pwm_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .trim(freq_trim_select),
        .tick(pwm_tick)
    );

    // general unit bundle
    assign gen_bus.tick = pwm_tick;
    assign gen_bus.freq_sel = general_freq_select;
    assign gen_bus.duty_data = general_duty_value;
    assign gen_bus.duty_wr = general_duty_wr;

    // led unit bundle, same base, own prescaler
    assign led_bus.tick = pwm_tick;
    assign led_bus.freq_sel = led_freq_select;
    assign led_bus.duty_data = led_duty_value;
    assign led_bus.duty_wr = led_duty_wr;

    // two independent generators on the one base
    pwm_unit u_general_pwm_unit (
        .clk(clk),
        .sys_rst(sys_rst),
        .p(gen_bus.unit)
    );

    pwm_unit u_led_pwm_unit (
        .clk(clk),
        .sys_rst(sys_rst),
        .p(led_bus.unit)
    );

    assign general_pwm_active = gen_bus.running;
    assign led_pwm_active = led_bus.running;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic cmd;
        logic oc;
        logic ot;
        logic inrush_trip;
        logic clr_req;
        logic clr_ok;
        logic win_end;
        logic restarting;
        logic drive_nxt;
        logic switch_on;
        logic drive_r;
        logic flag_r;
        logic inrush_r;
        logic ot_hold_r;
        logic oc_hold_r;
        logic win_run_r;
        logic thr_high_r;
        logic [CNT_W-1:0] rst_cnt_r;
        logic [CNT_W-1:0] win_cnt_r;
        logic [CNT_W-1:0] init_cnt_r;

        // channel command from any mapped source
        assign cmd = src_cmd(chan_src_sel[2*i +: 2], spi_on_cmd[i], gen_bus.out,
                             led_bus.out, parallel_map_zero[i], parallel_map_one[i],
                             parallel_input_zero, parallel_input_one);

        // sense is only meaningful while driven; overcurrent wins a tie
        assign oc = overcurrent_event[i] && drive_r;
        assign ot = overtemperature_event[i] && drive_r && !oc;
        assign inrush_trip = oc && inrush_r;
        assign clr_req = flag_clr_wr && flag_clr_mask[i];
        assign clr_ok = clr_req && !win_run_r;
        assign win_end = win_run_r && base_tick && (win_cnt_r == WINDOW_TICKS - CNT_ONE);
        assign restarting = (rst_cnt_r != '0);

        // comparator trip cuts drive on the next edge, no filter in the path
        assign drive_nxt = cmd && !oc && !ot && !ot_hold_r && !oc_hold_r
                           && !restarting;
        assign switch_on = drive_nxt && !drive_r;

        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                drive_r <= 1'b0;
            end else begin
                drive_r <= drive_nxt;
            end
        end

        // sticky flag; a new event in the clear cycle keeps it set
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                flag_r <= 1'b0;
            end else if (oc || ot) begin
                flag_r <= 1'b1;
            end else if (clr_ok) begin
                flag_r <= 1'b0;
            end
        end

        // permanent overcurrent latch only outside inrush mode
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                oc_hold_r <= 1'b0;
            end else if (oc && !inrush_r) begin
                oc_hold_r <= 1'b1;
            end else if (clr_ok) begin
                oc_hold_r <= 1'b0;
            end
        end

        // overtemperature latch holds in every mode until the flag clears
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                ot_hold_r <= 1'b0;
            end else if (ot) begin
                ot_hold_r <= 1'b1;
            end else if (clr_ok) begin
                ot_hold_r <= 1'b0;
            end
        end

        // inrush bit: software loads it, window end drops it, user off leaves it
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                inrush_r <= 1'b0;
            end else if (win_end) begin
                inrush_r <= 1'b0;
            end else if (inrush_wr) begin
                inrush_r <= inrush_wdata[i];
            end
        end

        // window arms on the first inrush trip and is not re-armed by later ones
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                win_run_r <= 1'b0;
                win_cnt_r <= '0;
            end else if (win_end || !inrush_r) begin
                win_run_r <= 1'b0;
                win_cnt_r <= '0;
            end else if (inrush_trip && !win_run_r) begin
                win_run_r <= 1'b1;
                win_cnt_r <= '0;
            end else if (win_run_r && base_tick) begin
                win_cnt_r <= win_cnt_r + CNT_ONE;
            end
        end

        // restart timer; drive returns on its own when it runs out
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                rst_cnt_r <= '0;
            end else if (inrush_trip) begin
                rst_cnt_r <= RESTART_TICKS;
            end else if (restarting && base_tick) begin
                rst_cnt_r <= rst_cnt_r - CNT_ONE;
            end
        end

        // initial high-threshold period; restarts inside the running inrush window do not re-open it
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                thr_high_r <= 1'b0;
                init_cnt_r <= '0;
            end else if (switch_on && !(inrush_r && win_run_r)) begin
                thr_high_r <= 1'b1;
                init_cnt_r <= '0;
            end else if (thr_high_r && base_tick) begin
                if (init_cnt_r == INIT_TICKS - CNT_ONE) begin
                    thr_high_r <= 1'b0;
                end else begin
                    init_cnt_r <= init_cnt_r + CNT_ONE;
                end
            end
        end

        // outputs straight from the channel flops
        assign channel_drive[i] = drive_r;
        assign overload_latch_flags[i] = flag_r;
        assign inrush_enable_bit[i] = inrush_r;
        assign inrush_window_run[i] = win_run_r;
        assign high_threshold_sel[i] = thr_high_r;

        sequence s_inrush_trip;
            inrush_r && drive_r && overcurrent_event[i];
        endsequence

        sequence s_restart_loaded;
            (rst_cnt_r == RESTART_TICKS) && !drive_r && flag_r;
        endsequence

        property p_latch_holds;
            @(posedge clk) disable iff (sys_rst)
                (oc_hold_r && !clr_req) |=> !drive_r;
        endproperty
        a_latch_holds: assert property (p_latch_holds) else $error("latched channel on");

        property p_restart;
            @(posedge clk) disable iff (sys_rst)
                s_inrush_trip |=> s_restart_loaded;
        endproperty
        a_restart: assert property (p_restart) else $error("inrush restart not armed");

        property p_inrush_drop;
            @(posedge clk) disable iff (sys_rst)
                $fell(inrush_r) |-> ($past(win_end) || $past(inrush_wr));
        endproperty
        a_inrush_drop: assert property (p_inrush_drop) else $error("inrush bit lost");

        property p_no_perm_latch;
            @(posedge clk) disable iff (sys_rst)
                (inrush_r && oc) |=> (flag_r && !oc_hold_r);
        endproperty
        a_no_perm_latch: assert property (p_no_perm_latch) else $error("inrush latched");

        property p_clear_ignored;
            @(posedge clk) disable iff (sys_rst)
                (win_run_r && flag_r && clr_req) |=> flag_r;
        endproperty
        a_clear_ignored: assert property (p_clear_ignored) else $error("clear in window");

        property p_overtemp;
            @(posedge clk) disable iff (sys_rst)
                ot |=> (ot_hold_r && flag_r && !drive_r) ##1 (!drive_r || $past(clr_ok));
        endproperty
        a_overtemp: assert property (p_overtemp) else $error("overtemp did not hold off");

        property p_window_end;
            @(posedge clk) disable iff (sys_rst)
                win_end |=> (!inrush_r && !win_run_r);
        endproperty
        a_window_end: assert property (p_window_end) else $error("window end missed");

        property p_immediate_off;
            @(posedge clk) disable iff (sys_rst)
                (drive_r && overcurrent_event[i]) |=> !drive_r;
        endproperty
        a_immediate_off: assert property (p_immediate_off) else $error("slow trip");

        property p_no_reopen;
            @(posedge clk) disable iff (sys_rst)
                (win_run_r && inrush_r && !thr_high_r && !switch_on)
                    ##1 (switch_on && win_run_r && inrush_r) |=> !thr_high_r;
        endproperty
        a_no_reopen: assert property (p_no_reopen) else $error("initial period reopened");

        property p_pin_priority;
            @(posedge clk) disable iff (sys_rst)
                (chan_src_sel[2*i +: 2] == SRC_PIN && parallel_map_zero[i]
                    && parallel_map_one[i] && !parallel_input_zero && parallel_input_one)
                    |-> !cmd;
        endproperty
        a_pin_priority: assert property (p_pin_priority) else $error("pin one won");
    end

endmodule // lowside_inrush_and_pwm_control

// >>> hdl/pwm_if.sv
// bundle between the controller top and one pwm unit
// assumes the top drives the control side from its own ports, except tick, which comes from its trimmed tick generator
`timescale 1ns/1ps
interface pwm_if;
    logic tick;
    logic [1:0] freq_sel;
    logic [7:0] duty_data;
    logic duty_wr;
    logic out;
    logic running;

    modport unit(input tick, input freq_sel, input duty_data, input duty_wr,
                 output out, output running);
    modport ctrl(output tick, output freq_sel, output duty_data, output duty_wr,
                 input out, input running);
endinterface

// >>> hdl/pwm_unit.sv
// one pwm generator: prescaler, 255-step period, double-buffered duty
// assumes tick is a one-cycle enable at the trimmed base rate
`timescale 1ns/1ps
module pwm_unit
    import lowside_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control and output bundle
    pwm_if.unit p
);
    logic [7:0] presc_r;
    logic [7:0] step_r;
    logic [7:0] cur_r;
    logic [7:0] pend_r;
    logic pend_v_r;
    logic run_r;
    logic out_r;
    logic presc_wrap;
    logic period_end;

    assign presc_wrap = run_r && p.tick && (presc_r == div_limit(p.freq_sel));
    assign period_end = presc_wrap && (step_r == STEP_LAST);
    assign p.out = out_r;
    assign p.running = run_r;

    // first duty write starts the unit, later writes never restart the period
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_r <= 1'b0;
            presc_r <= 8'h00;
            step_r <= 8'h00;
        end else if (p.duty_wr && !run_r) begin
            run_r <= 1'b1;
            presc_r <= 8'h00;
            step_r <= 8'h00;
        end else if (run_r && p.tick) begin
            presc_r <= presc_wrap ? 8'h00 : presc_r + 8'h01;
            if (presc_wrap) begin
                step_r <= (step_r == STEP_LAST) ? 8'h00 : step_r + 8'h01;
            end
        end
    end

    // duty shadow: taken at period end, or at once from 0%
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur_r <= DUTY_ZERO;
            pend_r <= DUTY_ZERO;
            pend_v_r <= 1'b0;
        end else if (p.duty_wr && (!run_r || cur_r == DUTY_ZERO)) begin
            cur_r <= p.duty_data;
            pend_v_r <= 1'b0;
        end else if (p.duty_wr) begin
            pend_r <= p.duty_data;
            pend_v_r <= 1'b1;
        end else if (period_end && pend_v_r) begin
            cur_r <= pend_r;
            pend_v_r <= 1'b0;
        end
    end

    // comparator; all ones bypasses the compare so the output never dips
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_r <= 1'b0;
        end else begin
            out_r <= run_r && ((cur_r == DUTY_FULL) || (step_r < cur_r));
        end
    end

    property p_full_on;
        @(posedge clk) disable iff (sys_rst) (run_r && cur_r == DUTY_FULL) |=> out_r;
    endproperty
    a_full_on: assert property (p_full_on) else $error("full duty output dropped");

    property p_zero_immediate;
        @(posedge clk) disable iff (sys_rst)
            (p.duty_wr && run_r && cur_r == DUTY_ZERO) |=> (cur_r == $past(p.duty_data));
    endproperty
    a_zero_immediate: assert property (p_zero_immediate) else $error("duty from 0 late");

    property p_wait_period;
        @(posedge clk) disable iff (sys_rst)
            (p.duty_wr && run_r && cur_r != DUTY_ZERO) |=> (cur_r == $past(cur_r));
    endproperty
    a_wait_period: assert property (p_wait_period) else $error("duty taken mid period");

    property p_start;
        @(posedge clk) disable iff (sys_rst) (p.duty_wr && !run_r) |=> (run_r && step_r == 8'h00);
    endproperty
    a_start: assert property (p_start) else $error("duty write did not start unit");
endmodule // pwm_unit

// >>> test/mcu_model.sv
// controller-side write strobes
// assumes calls from the bench; changes on falling edges
`timescale 1ns/1ps
module mcu_model (
    // clock
    input wire logic clk,
    // strobes and data
    output logic inrush_wr,
    output logic [7:0] inrush_wdata,
    output logic flag_clr_wr,
    output logic [7:0] flag_clr_mask,
    output logic general_duty_wr,
    output logic [7:0] general_duty_value,
    output logic led_duty_wr,
    output logic [7:0] led_duty_value
);
    // idle state at time zero
    initial begin
        {inrush_wr, flag_clr_wr, general_duty_wr, led_duty_wr} = 4'h0;
        {inrush_wdata, flag_clr_mask, general_duty_value, led_duty_value} = 32'h0;
    end
    // strobe held over one rising edge, data kept after
    task automatic lamp_inrush_mode(logic [7:0] d);
        @(negedge clk) {inrush_wr, inrush_wdata} = {1'b1, d};
        @(negedge clk) inrush_wr = 1'b0;
    endtask
    // flag clear, meant for after the window ends
    task automatic clr(logic [7:0] d);
        @(negedge clk) {flag_clr_wr, flag_clr_mask} = {1'b1, d};
        @(negedge clk) flag_clr_wr = 1'b0;
    endtask
    // duty writes come after mapping is set
    task automatic gen(logic [7:0] d);
        @(negedge clk) {general_duty_wr, general_duty_value} = {1'b1, d};
        @(negedge clk) general_duty_wr = 1'b0;
    endtask
    task automatic led(logic [7:0] d);
        @(negedge clk) {led_duty_wr, led_duty_value} = {1'b1, d};
        @(negedge clk) led_duty_wr = 1'b0;
    endtask
endmodule // mcu_model

// >>> test/tb_lowside_inrush_and_pwm_control.sv
// self-checking bench for the channel controller
// assumes mcu_model makes the strobes; bench drives levels
`timescale 1ns/1ps
module tb_lowside_inrush_and_pwm_control;
    logic clk = 1'b0;
    logic sys_rst, parallel_input_zero, parallel_input_one;
    logic [7:0] spi_on_cmd, parallel_map_zero, parallel_map_one;
    logic [7:0] overcurrent_event, overtemperature_event;
    logic [15:0] chan_src_sel;
    logic [1:0] general_freq_select, led_freq_select, freq_trim_select;
    logic inrush_wr, flag_clr_wr, general_duty_wr, led_duty_wr;
    logic general_pwm_active, led_pwm_active;
    logic [7:0] inrush_wdata, flag_clr_mask, general_duty_value, led_duty_value;
    logic [7:0] channel_drive, high_threshold_sel, overload_latch_flags;
    logic [7:0] inrush_enable_bit, inrush_window_run;
    int err_total = 0, check_count = 0, cyc_n = 0;
    // short counts: window 200, restart 20, initial 30 base ticks
    lowside_inrush_and_pwm_control #(.WINDOW_TICKS(19'h000c8), .RESTART_TICKS(19'h00014),
        .INIT_TICKS(19'h0001e)) DUT (.clk, .sys_rst, .spi_on_cmd, .chan_src_sel,
        .parallel_map_zero, .parallel_map_one, .parallel_input_zero, .parallel_input_one,
        .inrush_wr, .inrush_wdata, .flag_clr_wr, .flag_clr_mask, .general_duty_wr,
        .general_duty_value, .general_freq_select, .led_duty_wr, .led_duty_value,
        .led_freq_select, .freq_trim_select, .overcurrent_event, .overtemperature_event,
        .channel_drive, .high_threshold_sel, .overload_latch_flags, .inrush_enable_bit,
        .inrush_window_run, .general_pwm_active, .led_pwm_active);
    mcu_model mcu (.clk, .inrush_wr, .inrush_wdata, .flag_clr_wr, .flag_clr_mask,
        .general_duty_wr, .general_duty_value, .led_duty_wr, .led_duty_value);
    // 50 ns clock
    initial forever #25 clk = ~clk;
    // hang guard, well past the longest pwm wait
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 45000) begin
            err_total++;
            results();
        end
    end
    task automatic w(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ch0: plain latch, threshold period
    task automatic t_latch();
        spi_on_cmd = 8'h01;
        w(2);
        chk("thr", 8'h01, high_threshold_sel);
        w(100);
        chk("thr", 8'h00, high_threshold_sel);
        overcurrent_event = 8'h01;
        w(1);
        overcurrent_event = 8'h00;
        chk("drv", 8'h00, channel_drive);
        w(30);
        chk("drv", 8'h00, channel_drive);
        mcu.clr(8'h01);
        w(2);
        chk("drv", 8'h01, channel_drive);
        $display("latch done");
    endtask
    // ch1: inrush restart, blocked clear, window end
    task automatic t_inrush();
        mcu.lamp_inrush_mode(8'h02);
        spi_on_cmd = 8'h03;
        // let the initial period run out first, so the restart must not reopen it
        w(80);
        overcurrent_event = 8'h02;
        w(1);
        overcurrent_event = 8'h00;
        chk("flg", 8'h02, overload_latch_flags);
        chk("win", 8'h02, inrush_window_run);
        mcu.clr(8'h02);
        w(1);
        chk("flg", 8'h02, overload_latch_flags);
        w(40);
        chk("drv", 8'h01, channel_drive);
        w(20);
        chk("drv", 8'h03, channel_drive);
        chk("thr", 8'h00, high_threshold_sel & 8'h02);
        spi_on_cmd = 8'h01;
        w(420);
        chk("bim", 8'h02, inrush_enable_bit);
        w(30);
        chk("bim", 8'h00, inrush_enable_bit);
        mcu.clr(8'h02);
        w(2);
        chk("flg", 8'h00, overload_latch_flags);
        $display("inrush done");
    endtask
    // ch2 overtemperature, ch4 pin priority
    task automatic t_temp_pin();
        spi_on_cmd = 8'h05;
        w(2);
        overtemperature_event = 8'h04;
        w(1);
        overtemperature_event = 8'h00;
        w(10);
        chk("drv", 8'h01, channel_drive);
        mcu.clr(8'h04);
        w(2);
        chk("drv", 8'h05, channel_drive);
        chan_src_sel = 16'h0300;
        {parallel_map_zero, parallel_map_one, parallel_input_one} = {8'h10, 8'h10, 1'b1};
        w(2);
        chk("pin", 8'h00, channel_drive & 8'h10);
        {parallel_input_zero, parallel_input_one} = 2'h2;
        w(2);
        chk("pin", 8'h10, channel_drive & 8'h10);
        $display("temp pin done");
    endtask
    // ch3 general, ch5 led; period 255*32 ticks, trim 01 gives 92/200 ticks a clock:
    // about 17739 clocks instead of the nominal 20400
    task automatic t_pwm();
        freq_trim_select = 2'h1;
        chan_src_sel = 16'h0840;
        mcu.led(8'hff);
        w(2);
        chk("led", 8'h21, {2'h0, channel_drive[5], 4'h0, led_pwm_active});
        mcu.gen(8'h00);
        w(10);
        chk("gen", 8'h01, {channel_drive[3:0] & 4'h8, 3'h0, general_pwm_active});
        mcu.gen(8'h80);
        w(20);
        chk("gen", 8'h08, channel_drive & 8'h08);
        mcu.gen(8'hff);
        w(12000);
        chk("gen", 8'h00, channel_drive & 8'h08);
        w(6000);
        chk("gen", 8'h08, channel_drive & 8'h08);
        w(9000);
        chk("gen", 8'h08, channel_drive & 8'h08);
        $display("pwm done");
    endtask
    initial begin
        {sys_rst, parallel_input_zero, parallel_input_one} = 3'h4;
        {spi_on_cmd, parallel_map_zero, parallel_map_one} = 24'h000000;
        {overcurrent_event, overtemperature_event, chan_src_sel} = 32'h00000000;
        {general_freq_select, led_freq_select, freq_trim_select} = 6'h3c;
        w(3);
        sys_rst = 1'b0;
        w(1);
        chk("rst", 8'h00, channel_drive | overload_latch_flags | inrush_enable_bit);
        t_latch();
        t_inrush();
        t_temp_pin();
        t_pwm();
        results();
    end
endmodule // tb_lowside_inrush_and_pwm_control
